//--- design/dlq_irq_top.sv
// Purpose: status and enable logic of the second data link controller
// Assumes: register port strobes are one cycle long and never overlap
// Notes: status bits clear on read; the message type bit is a live input
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`include "dlq_irq_map.svh"

// Function
// - end of message sets bit 3
// - status sticky until read, read clears
// - bad check sequence sets bit 2
// - seven ones set abort bit 1
// - flag octet sets idle bit 0
// - enable bit 6 gates transmit begin
// - enable bit 5 gates receive begin
// - enable bit 4 gates transmit finish
// - enable bit 3 gates receive finish
// - transmit begin and finish set status
// - enable bits 2..0 gate low events
module dlq_irq_top
  import dlq_irq_pkg::*;
#(
  parameter int ABORT_LEN = 7
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // register port
  input wire logic [15:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  // receive controller events
  input wire logic rx_msg_done_in,
  input wire logic rx_buf_full_in,
  input wire logic rx_fcs_bad_in,
  input wire logic rx_begin_in,
  input wire logic rx_msg_type_in,
  input wire logic rx_bit_valid_in,
  input wire logic rx_bit_in,
  // transmit controller events
  input wire logic tx_begin_in,
  input wire logic tx_end_in,
  // interrupt request
  output logic irq_out
);

  // the abort check below is only written for the seven-bit abort run
  if (ABORT_LEN != 7) begin : g_len_chk
    $error("ABORT_LEN must be 7");
  end

  // ==========================================
  // decode
  logic status_sel;
  logic enable_sel;
  logic status_rd;
  assign status_sel = addr_in == `DLQ_STATUS_OFS;
  assign enable_sel = addr_in == `DLQ_ENABLE_OFS;
  assign status_rd = rd_in && status_sel;

  // ==========================================
  // event sources
  logic flag_seen;
  logic abort_seen;
  dlq_events_t ev;
  dlq_events_t status_r;
  dlq_events_t status_nxt;
  dlq_events_t enable;

  dlq_rx_watch #(
    .ABORT_LEN(ABORT_LEN)
  ) u_watch (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .bit_valid_in(rx_bit_valid_in),
    .bit_in(rx_bit_in),
    .flag_seen_out(flag_seen),
    .abort_seen_out(abort_seen)
  );

  dlq_enable_reg u_enable (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .wr_in(wr_in && enable_sel),
    .wdata_in(wdata_in),
    .enable_out(enable)
  );

  always_comb begin
    ev = '0;
    ev.rx_end = rx_msg_done_in || rx_buf_full_in;
    ev.fcs_err = rx_fcs_bad_in;
    ev.abort = abort_seen;
    ev.idle = flag_seen;
    ev.tx_begin = tx_begin_in;
    ev.tx_end = tx_end_in;
    ev.rx_begin = rx_begin_in;
  end

  // ==========================================
  // sticky status, an event in the read cycle survives the clear
  assign status_nxt = (status_rd ? dlq_events_t'('0) : status_r) | ev;

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      status_r <= `DLQ_STATUS_RST;
    end else begin
      status_r <= status_nxt;
    end
  end

  // ==========================================
  // read data, one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_out <= 8'h00;
    end else if (status_rd) begin
      rdata_out <= {rx_msg_type_in, status_r};
    end else if (rd_in && enable_sel) begin
      rdata_out <= {1'b0, enable};
    end else begin
      rdata_out <= 8'h00;
    end
  end

  // ==========================================
  // request, registered so it is glitch free
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(status_nxt & enable);
    end
  end

  // ==========================================
  // checks
  sequence read_status_s;
    rd_in && status_sel;
  endsequence

  sequence no_read_s;
    !(rd_in && status_sel);
  endsequence

  sticky_hold_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    $rose(status_r.fcs_err) && !rd_in [*1] ##1 (!rd_in) |-> status_r.fcs_err)
    else $error("status bit lost without read");

  read_clears_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (read_status_s and (ev == '0)) |=> status_r == '0)
    else $error("read did not clear status");

  rx_end_set_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    rx_msg_done_in || rx_buf_full_in |=> status_r.rx_end)
    else $error("end of message not recorded");

  fcs_set_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    rx_fcs_bad_in |=> status_r.fcs_err)
    else $error("check sequence error not recorded");

  abort_set_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (rx_bit_valid_in && !rx_bit_in) ##1 (rx_bit_valid_in && rx_bit_in) [*7] |=> status_r.abort)
    else $error("abort run not recorded");

  idle_set_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    rx_bit_valid_in && {rx_bit_in, u_watch.shift_r[7:1]} == `DLQ_FLAG_OCTET |=> status_r.idle)
    else $error("flag octet not recorded");

  tx_status_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    tx_begin_in && tx_end_in |=> status_r.tx_begin && status_r.tx_end)
    else $error("transmit events not recorded");

  irq_gate_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    ##1 irq_out == |($past(status_nxt) & $past(enable)))
    else $error("request disagrees with enabled status");

  enable_write_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    wr_in && enable_sel |=> enable == $past(wdata_in[6:0]))
    else $error("enable write not stored");

  masked_quiet_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    enable == '0 |=> !irq_out)
    else $error("request with all enables off");

  sticky_all_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    no_read_s |=> (status_r & $past(status_r)) == $past(status_r))
    else $error("status bit dropped without read");

  write_ignored_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    wr_in && !rd_in && status_sel && ev == '0 |=> status_r == $past(status_r))
    else $error("status changed by a write");

  read_snapshot_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    read_status_s |=> rdata_out == {$past(rx_msg_type_in), $past(status_r)})
    else $error("status read data wrong");

  enable_read_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    rd_in && enable_sel |=> rdata_out == {1'b0, $past(enable)})
    else $error("enable read data wrong");

  unmapped_zero_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    !(rd_in && (status_sel || enable_sel)) |=> rdata_out == 8'h00)
    else $error("read data outside a register read");

  rx_begin_set_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    rx_begin_in |=> status_r.rx_begin)
    else $error("receive begin not recorded");

  tx_begin_set_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    tx_begin_in |=> status_r.tx_begin)
    else $error("transmit begin not recorded");

  tx_end_set_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    tx_end_in |=> status_r.tx_end)
    else $error("transmit finish not recorded");

  enable_hold_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    !(wr_in && enable_sel) |=> $stable(enable))
    else $error("enable changed without a write");

  irq_raise_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (status_nxt & enable) != '0 |=> irq_out)
    else $error("request missing for enabled status");

  irq_release_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (status_nxt & enable) == '0 |=> !irq_out)
    else $error("request held with nothing enabled");

endmodule : dlq_irq_top

//--- design/dlq_irq_map.svh
// Purpose: register map and field layout of the second data link interrupt block
// Assumes: byte-wide registers on a plain address port
// Notes: offsets are channel-relative
`ifndef DLQ_IRQ_MAP_SVH
`define DLQ_IRQ_MAP_SVH

// ==========================================
// register offsets
`define DLQ_STATUS_OFS 16'h0B16
`define DLQ_ENABLE_OFS 16'h0B17

// ==========================================
// status and enable bit positions
`define DLQ_BIT_IDLE 0
`define DLQ_BIT_ABORT 1
`define DLQ_BIT_FCS 2
`define DLQ_BIT_RX_END 3
`define DLQ_BIT_TX_END 4
`define DLQ_BIT_RX_BEGIN 5
`define DLQ_BIT_TX_BEGIN 6
`define DLQ_BIT_MSG_TYPE 7

// ==========================================
// reset values and patterns
`define DLQ_STATUS_RST 7'h00
`define DLQ_ENABLE_RST 7'h00
`define DLQ_FLAG_OCTET 8'h7E
`define DLQ_ABORT_ONES 3'h7

`endif

//--- design/dlq_irq_pkg.sv
// Purpose: types of the second data link interrupt block
// Assumes: nothing beyond the map header
// Notes: events travel as one packed struct
package dlq_irq_pkg;

  // ==========================================
  // event group, one bit per status source
  typedef struct packed {
    logic tx_begin;
    logic rx_begin;
    logic tx_end;
    logic rx_end;
    logic fcs_err;
    logic abort;
    logic idle;
  } dlq_events_t;

  // ==========================================
  // receive bit watcher state
  typedef enum logic [1:0] {
    DLQ_HUNT = 2'b00,
    DLQ_RUN = 2'b01,
    DLQ_HOLD = 2'b10
  } dlq_watch_t;

endpackage : dlq_irq_pkg

//--- design/dlq_rx_watch.sv
// Purpose: spots flag octets and abort runs in the incoming data link bits
// Assumes: one bit per cycle while bit_valid_in is high
// Notes: abort fires once per run of ABORT_LEN or more ones
`timescale 1ns/1ps
`include "dlq_irq_map.svh"
module dlq_rx_watch
  import dlq_irq_pkg::*;
#(
  parameter int ABORT_LEN = 7
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // serial data
  input wire logic bit_valid_in,
  input wire logic bit_in,
  // detections
  output logic flag_seen_out,
  output logic abort_seen_out
);

  // the three-bit ones counter cannot serve longer runs
  if (ABORT_LEN < 2 || ABORT_LEN > 7) begin : g_len_chk
    $error("ABORT_LEN out of range");
  end

  // ==========================================
  // shifter and ones counter
  logic [7:0] shift_r;
  logic [2:0] ones_r;
  dlq_watch_t st_r;

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      shift_r <= 8'h00;
    end else if (bit_valid_in) begin
      shift_r <= {bit_in, shift_r[7:1]};
    end
  end

  // a held state stops the abort repeating on a long run of ones
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ones_r <= 3'h0;
      st_r <= DLQ_HUNT;
    end else if (bit_valid_in) begin
      case (st_r)
        DLQ_HUNT: begin
          ones_r <= bit_in ? 3'h1 : 3'h0;
          st_r <= bit_in ? DLQ_RUN : DLQ_HUNT;
        end
        DLQ_RUN: begin
          if (!bit_in) begin
            ones_r <= 3'h0;
            st_r <= DLQ_HUNT;
          end else if (ones_r == 3'(ABORT_LEN - 1)) begin
            st_r <= DLQ_HOLD;
          end else begin
            ones_r <= ones_r + 3'h1;
          end
        end
        DLQ_HOLD: begin
          if (!bit_in) begin
            ones_r <= 3'h0;
            st_r <= DLQ_HUNT;
          end
        end
        default: begin
          st_r <= DLQ_HUNT;
        end
      endcase
    end
  end

  assign flag_seen_out = bit_valid_in && ({bit_in, shift_r[7:1]} == `DLQ_FLAG_OCTET);
  assign abort_seen_out = bit_valid_in && bit_in && st_r == DLQ_RUN
    && ones_r == 3'(ABORT_LEN - 1);

endmodule : dlq_rx_watch

//--- design/dlq_enable_reg.sv
// Purpose: interrupt enable register, seven writable bits
// Assumes: byte write strobe from the register port
// Notes: bit 7 is reserved and reads zero
`timescale 1ns/1ps
`include "dlq_irq_map.svh"
module dlq_enable_reg
  import dlq_irq_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // write side
  input wire logic wr_in,
  input wire logic [7:0] wdata_in,
  // stored enables
  output dlq_events_t enable_out
);

  // ==========================================
  // enable storage
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      enable_out <= `DLQ_ENABLE_RST;
    end else if (wr_in) begin
      enable_out <= wdata_in[6:0];
    end
  end

endmodule : dlq_enable_reg

//--- bench/dlq_irq_tb.sv
// Purpose: self-checking bench of the second data link interrupt block
// Assumes: serial detections are seen in the cycle of the last bit
// Notes: a cycle model runs beside the design and is compared every cycle out of reset
`timescale 1ns/1ps
`include "dlq_irq_map.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  // ==========================================
  // signals
  logic sys_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [15:0] addr_in = 16'h0000;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [7:0] rdata_out;
  logic rx_msg_done_in = 1'b0;
  logic rx_buf_full_in = 1'b0;
  logic rx_fcs_bad_in = 1'b0;
  logic rx_begin_in = 1'b0;
  logic rx_msg_type_in = 1'b0;
  logic rx_bit_valid_in = 1'b0;
  logic rx_bit_in = 1'b0;
  logic tx_begin_in = 1'b0;
  logic tx_end_in = 1'b0;
  logic irq_out;
  logic [6:0] st, en, ev;
  logic [7:0] sh, exp_rd;
  logic exp_irq;
  int ones, n_fail = 0, n_tests = 0;
  logic [15:0] adr_tab [4] = '{`DLQ_STATUS_OFS, `DLQ_ENABLE_OFS, 16'h0B15, 16'h0B18};

  always #10 sys_clk_in = ~sys_clk_in;

  dlq_irq_top #(.ABORT_LEN(7)) dlq_irq_top_inst (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .rx_msg_done_in(rx_msg_done_in),
    .rx_buf_full_in(rx_buf_full_in), .rx_fcs_bad_in(rx_fcs_bad_in), .rx_begin_in(rx_begin_in),
    .rx_msg_type_in(rx_msg_type_in), .rx_bit_valid_in(rx_bit_valid_in), .rx_bit_in(rx_bit_in),
    .tx_begin_in(tx_begin_in), .tx_end_in(tx_end_in), .irq_out(irq_out)
  );

  // ==========================================
  // cycle model, blocking so it sees pre-edge inputs
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st = 7'h00;
      en = 7'h00;
      sh = 8'h00;
      ones = 0;
      exp_rd = 8'h00;
      exp_irq = 1'b0;
    end else begin
      ev = {tx_begin_in, rx_begin_in, tx_end_in, rx_msg_done_in | rx_buf_full_in, rx_fcs_bad_in, 2'b00};
      if (rx_bit_valid_in) begin
        sh = {rx_bit_in, sh[7:1]};
        ones = rx_bit_in ? ones + 1 : 0;
        ev[1] = (ones == 7);
        ev[0] = (sh == `DLQ_FLAG_OCTET);
      end
      exp_rd = 8'h00;
      if (rd_in && addr_in == `DLQ_STATUS_OFS) begin
        exp_rd = {rx_msg_type_in, st};
        st = ev;
      end else begin
        st = st | ev;
      end
      if (rd_in && addr_in == `DLQ_ENABLE_OFS) exp_rd = {1'b0, en};
      // the request follows the enable in force before this edge's write
      exp_irq = |(st & en);
      if (wr_in && addr_in == `DLQ_ENABLE_OFS) en = wdata_in[6:0];
    end
  end

  always @(negedge sys_clk_in) begin
    if (rst_n_in) begin
      `CHK(rdata_out, exp_rd)
      `CHK(irq_out, exp_irq)
    end
  end

  // ==========================================
  // drivers and verdict
  task automatic drive(input logic [5:0] e, input logic r, input logic w, input logic [15:0] a,
                       input logic [7:0] d, input logic vb, input logic b);
    @(posedge sys_clk_in);
    {tx_begin_in, rx_begin_in, tx_end_in, rx_buf_full_in, rx_msg_done_in, rx_fcs_bad_in} <= e;
    rd_in <= r;
    wr_in <= w;
    addr_in <= a;
    wdata_in <= d;
    rx_bit_valid_in <= vb;
    rx_bit_in <= b;
  endtask : drive

  task automatic idle(input int n);
    repeat (n) drive(6'h00, 1'b0, 1'b0, 16'h0000, 8'h00, 1'b0, 1'b0);
  endtask : idle

  task automatic send_byte(input logic [7:0] v);
    for (int i = 0; i < 8; i++) drive(6'h00, 1'b0, 1'b0, 16'h0000, 8'h00, 1'b1, v[i]);
  endtask : send_byte

  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict

  initial begin
    repeat (20000) @(posedge sys_clk_in);
    n_fail++;
    give_verdict();
  end

  // ==========================================
  // scenarios
  initial begin
    logic [15:0] a;
    logic [7:0] fl;
    int op;
    void'($urandom(32'h2f8306e4));
    repeat (3) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    // reset values, unmapped places and a status write that must not stick
    for (int i = 0; i < 4; i++) drive(6'h00, 1'b1, 1'b0, adr_tab[i], 8'h00, 1'b0, 1'b0);
    drive(6'h00, 1'b0, 1'b1, `DLQ_STATUS_OFS, 8'hFF, 1'b0, 1'b0);
    drive(6'h00, 1'b0, 1'b1, 16'h0B18, 8'hFF, 1'b0, 1'b0);
    drive(6'h00, 1'b0, 1'b1, `DLQ_ENABLE_OFS, 8'hFF, 1'b0, 1'b0);
    drive(6'h00, 1'b1, 1'b0, `DLQ_ENABLE_OFS, 8'h00, 1'b0, 1'b0);
    // each source alone, then in the read cycle itself, read back to back
    for (int k = 0; k < 6; k++) begin
      drive(6'h01 << k, 1'b0, 1'b0, 16'h0000, 8'h00, 1'b0, 1'b0);
      drive(6'h00, 1'b1, 1'b0, `DLQ_STATUS_OFS, 8'h00, 1'b0, 1'b0);
      drive(6'h01 << k, 1'b1, 1'b0, `DLQ_STATUS_OFS, 8'h00, 1'b0, 1'b0);
      drive(6'h00, 1'b1, 1'b0, `DLQ_STATUS_OFS, 8'h00, 1'b0, 1'b0);
      drive(6'h00, 1'b1, 1'b0, `DLQ_STATUS_OFS, 8'h00, 1'b0, 1'b0);
    end
    // flag octet, an abort run of fourteen ones, random bits
    send_byte(`DLQ_FLAG_OCTET);
    send_byte(8'hFF);
    send_byte(8'h3F);
    for (int i = 0; i < 6; i++) send_byte(8'($urandom));
    send_byte(`DLQ_FLAG_OCTET);
    idle(6);
    drive(6'h00, 1'b1, 1'b0, `DLQ_STATUS_OFS, 8'h00, 1'b0, 1'b0);
    drive(6'h00, 1'b1, 1'b0, `DLQ_STATUS_OFS, 8'h00, 1'b0, 1'b0);
    // a whole message shows end and idle together, a full buffer only end
    fl = `DLQ_FLAG_OCTET;
    for (int i = 0; i < 8; i++) drive((i == 7) ? 6'h02 : 6'h00, 1'b0, 1'b0, 16'h0000, 8'h00, 1'b1, fl[i]);
    drive(6'h00, 1'b1, 1'b0, `DLQ_STATUS_OFS, 8'h00, 1'b0, 1'b0);
    drive(6'h04, 1'b0, 1'b0, 16'h0000, 8'h00, 1'b0, 1'b0);
    @(negedge sys_clk_in);
    `CHK({rdata_out[`DLQ_BIT_RX_END], rdata_out[`DLQ_BIT_IDLE]}, 2'b11)
    drive(6'h00, 1'b1, 1'b0, `DLQ_STATUS_OFS, 8'h00, 1'b0, 1'b0);
    drive(6'h00, 1'b0, 1'b0, 16'h0000, 8'h00, 1'b0, 1'b0);
    @(negedge sys_clk_in);
    `CHK({rdata_out[`DLQ_BIT_RX_END], rdata_out[`DLQ_BIT_IDLE]}, 2'b10)
    // random traffic, events against reads and enable writes
    for (int i = 0; i < 600; i++) begin
      op = $urandom_range(3);
      a = adr_tab[$urandom_range(3)];
      rx_msg_type_in <= 1'($urandom);
      drive(6'($urandom & $urandom & $urandom), op == 0, op == 1, a, 8'($urandom), 1'b0, 1'b0);
      if (i == 300) begin
        rst_n_in <= 1'b0;
        idle(2);
        rst_n_in <= 1'b1;
      end
    end
    idle(3);
    give_verdict();
  end
endmodule : tb
